// ---- bench/dma_far_model.sv ----
// Model of the external DMA controller that answers dma_req
`timescale 1ns/100ps
module dma_far_model #(
  parameter int ACK_DELAY = 3
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic dma_req,
  output logic dma_ack
);
  int cnt;
  ////////////////////////////////////////////////////////////////////////////
  // Moves one packet per request, then pulses ack for one cycle
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cnt <= 0;
      dma_ack <= 1'b0;
    end else begin
      dma_ack <= 1'b0;
      if (dma_req && !dma_ack) begin
        cnt <= cnt + 1;
        if (cnt == ACK_DELAY) begin
          dma_ack <= 1'b1;
          cnt <= 0;
        end
      end else begin
        cnt <= 0;
      end
    end
  end
endmodule : dma_far_model

// ---- bench/usb_endpoint_auto_dma_control_tb.sv ----
// Self-checking bench for the auto DMA control block
`timescale 1ns/100ps
module usb_endpoint_auto_dma_control_tb;
  logic ref_clk = 1'b0, reset = 1'b1, reg_write = 1'b0, reg_read = 1'b0;
  logic interface_select_pin = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, d;
  logic [5:0] ep_complete = 6'h00, fifo_warn = 6'h00, fifo_empty = 6'h00;
  logic [5:0] status_read = 6'h00, tx_last_set = 6'h00;
  logic [5:0] ep_reg_access = 6'h00, fifo_fw_access = 6'h00;
  logic [47:0] ep_status = 48'h0;
  logic pkt_done = 1'b0, pkt_ack = 1'b0, pkt_rx_err = 1'b0;
  logic pkt_toggle = 1'b0, pkt_short = 1'b0;
  logic dma_ack, dma_req, auto_rx_enable, auto_tx_enable, fifo_flush;
  logic tx_toggle_override, tx_toggle_value, alt_event_dma;
  int err_total = 0, tests_run = 0;
  usb_endpoint_auto_dma_control u_usb_endpoint_auto_dma_control (
    .ref_clk, .reset, .reg_addr, .reg_wdata, .reg_write, .reg_read,
    .reg_rdata, .interface_select_pin, .ep_complete, .fifo_warn,
    .fifo_empty, .status_read, .tx_last_set, .ep_reg_access,
    .fifo_fw_access, .ep_status, .pkt_done, .pkt_ack, .pkt_rx_err,
    .pkt_toggle, .pkt_short, .dma_ack, .dma_req, .auto_rx_enable,
    .auto_tx_enable, .fifo_flush, .tx_toggle_override, .tx_toggle_value,
    .alt_event_dma);
  dma_far_model u_dma_far_model (.ref_clk, .reset, .dma_req, .dma_ack);
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task chk(input logic [7:0] s, input logic [7:0] e);
    tests_run++;
    if (s !== e) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge ref_clk);
    reg_write <= 1'b0;
  endtask : wr
  // Read data is valid only in the cycle after the strobe
  task rd(input logic [3:0] a);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge ref_clk);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  task wait_req(input logic v);
    #1;
    for (int i = 0; i < 6 && dma_req !== v; i++) begin
      @(posedge ref_clk);
      #1;
    end
    chk({7'h00, dma_req}, {7'h00, v});
  endtask : wait_req
  task pkt(input logic ack, input logic err);
    @(posedge ref_clk);
    pkt_done <= 1'b1;
    pkt_ack <= ack;
    pkt_rx_err <= err;
    @(posedge ref_clk);
    pkt_done <= 1'b0;
  endtask : pkt
  task results;
    $display("Comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : results
  ////////////////////////////////////////////////////////////////////////////
  task t_reset;
    for (int a = 0; a < 8; a++) begin
      rd(a[3:0]);
      chk(d, 8'h00);
    end
  endtask : t_reset
  task t_serial;
    @(posedge ref_clk);
    interface_select_pin <= 1'b1;
    wr(4'h0, 8'h80);
    rd(4'h0);
    chk(d & 8'h80, 8'h00);
    @(posedge ref_clk);
    interface_select_pin <= 1'b0;
  endtask : t_serial
  task t_done;
    wr(4'h0, 8'h80);
    @(posedge ref_clk);
    ep_complete <= 6'h01;
    wait_req(1'b1);
    @(posedge ref_clk);
    status_read <= 6'h01;
    @(posedge ref_clk);
    status_read <= 6'h00;
    ep_complete <= 6'h00;
    wait_req(1'b0);
    wr(4'h0, 8'h00);
    @(posedge ref_clk);
    ep_complete <= 6'h01;
    repeat (4) @(posedge ref_clk);
    wait_req(1'b0);
    @(posedge ref_clk);
    ep_complete <= 6'h00;
  endtask : t_done
  task t_warn;
    wr(4'h0, 8'h89);
    @(posedge ref_clk);
    fifo_warn <= 6'h02;
    wait_req(1'b1);
    @(posedge ref_clk);
    fifo_empty <= 6'h02;
    wait_req(1'b0);
    @(posedge ref_clk);
    fifo_warn <= 6'h00;
    fifo_empty <= 6'h00;
    wr(4'h0, 8'h00);
  endtask : t_warn
  task t_mirror;
    @(posedge ref_clk);
    ep_status <= 48'h0000_0000_a500;
    wr(4'h0, 8'h01);
    for (int i = 0; i < 2; i++) begin
      rd(4'h3);
      chk(d, 8'ha5);
    end
  endtask : t_mirror
  task t_halt;
    wr(4'h1, 8'h0f);
    wr(4'h2, 8'h01);
    wr(4'h0, 8'h80);
    wr(4'h0, 8'h00);
    rd(4'h1);
    chk(d, 8'h01);
    chk({7'h00, alt_event_dma}, 8'h01);
    wr(4'h1, 8'h0f);
    rd(4'h1);
    chk(d, 8'h00);
    chk({7'h00, alt_event_dma}, 8'h00);
  endtask : t_halt
  task t_toggle;
    wr(4'h0, 8'h20);
    rd(4'h1);
    chk(d, 8'h20);
    chk({7'h00, tx_toggle_value}, 8'h01);
    wr(4'h0, 8'h00);
    rd(4'h1);
    chk(d, 8'h00);
  endtask : t_toggle
  task t_err;
    wr(4'h0, 8'h80);
    pkt(1'b0, 1'b0);
    rd(4'h1);
    chk(d & 8'h02, 8'h02);
    wr(4'h1, 8'h0f);
    wr(4'h0, 8'h81);
    pkt(1'b1, 1'b1);
    rd(4'h1);
    chk(d & 8'h02, 8'h02);
    wr(4'h0, 8'h00);
  endtask : t_err
  // Receive endpoint in auto mode, request timing bit set but ignored
  task t_auto;
    wr(4'h1, 8'h0f);
    wr(4'h4, 8'h01);
    wr(4'h0, 8'h99);
    #1;
    for (int i = 0; i < 6 && fifo_flush !== 1'b1; i++) begin
      @(posedge ref_clk);
      #1;
    end
    chk({7'h00, fifo_flush}, 8'h01);
    chk({7'h00, auto_rx_enable}, 8'h01);
    pkt(1'b1, 1'b0);
    wait_req(1'b1);
    repeat (10) @(posedge ref_clk);
    rd(4'h4);
    chk(d, 8'h00);
    rd(4'h1);
    chk(d, 8'h20);
    wr(4'h0, 8'h81);
    repeat (4) @(posedge ref_clk);
    rd(4'h1);
    chk(d & 8'h01, 8'h01);
    wr(4'h0, 8'h00);
  endtask : t_auto
  // Transmit endpoint in auto mode: fill first, then send; count at zero
  task t_auto_tx;
    wr(4'h1, 8'h0f);
    wr(4'h4, 8'h00);
    wr(4'h0, 8'hb0);
    wait_req(1'b1);
    chk({6'h00, tx_toggle_override, tx_toggle_value}, 8'h03);
    chk({7'h00, auto_tx_enable}, 8'h00);
    repeat (6) @(posedge ref_clk);
    #1;
    chk({6'h00, auto_tx_enable, dma_req}, 8'h02);
    @(posedge ref_clk);
    pkt_toggle <= 1'b1;
    pkt(1'b1, 1'b0);
    rd(4'h1);
    chk(d, 8'h04);
    chk({6'h00, tx_toggle_override, dma_req}, 8'h00);
    @(posedge ref_clk);
    pkt_toggle <= 1'b0;
    wr(4'h1, 8'h0f);
    @(posedge ref_clk);
    ep_reg_access <= 6'h01;
    @(posedge ref_clk);
    ep_reg_access <= 6'h00;
    rd(4'h1);
    chk(d & 8'h01, 8'h01);
    chk({7'h00, dma_req}, 8'h00);
    wr(4'h0, 8'h00);
  endtask : t_auto_tx
  // Firmware touches the FIFO while a request stands
  task t_fw_access;
    wr(4'h1, 8'h0f);
    wr(4'h0, 8'h80);
    @(posedge ref_clk);
    ep_complete <= 6'h01;
    wait_req(1'b1);
    @(posedge ref_clk);
    fifo_fw_access <= 6'h01;
    @(posedge ref_clk);
    fifo_fw_access <= 6'h00;
    ep_complete <= 6'h00;
    wait_req(1'b0);
    rd(4'h1);
    chk(d & 8'h01, 8'h01);
    wr(4'h0, 8'h00);
  endtask : t_fw_access
  // One retry allowed: first bad packet swallowed, second flagged
  task t_retry;
    wr(4'h1, 8'h0f);
    wr(4'h5, 8'h81);
    wr(4'h0, 8'h91);
    pkt(1'b1, 1'b1);
    rd(4'h5);
    chk(d, 8'h80);
    rd(4'h1);
    chk(d & 8'h02, 8'h00);
    pkt(1'b1, 1'b1);
    rd(4'h1);
    chk(d & 8'h02, 8'h02);
    rd(4'h5);
    chk(d, 8'h81);
    wr(4'h0, 8'h00);
  endtask : t_retry
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge ref_clk);
    reset <= 1'b0;
    t_reset;
    t_serial;
    t_done;
    t_warn;
    t_mirror;
    t_halt;
    t_toggle;
    t_err;
    t_auto;
    t_auto_tx;
    t_fw_access;
    t_retry;
    results();
  end
  // Whole run needs well under 2000 cycles
  initial begin
    #300000;
    err_total++;
    results();
  end
endmodule : usb_endpoint_auto_dma_control_tb

// ---- rtl/dma_params.svh ----
// Offsets, field positions, reset values of the auto DMA control block
`ifndef DMA_PARAMS_SVH
`define DMA_PARAMS_SVH
`define OFF_CONTROL 4'h0
`define OFF_EVENT 4'h1
`define OFF_MASK 4'h2
`define OFF_MIRROR 4'h3
`define OFF_COUNT 4'h4
`define OFF_RETRY 4'h5
`define CTL_EN 7
`define CTL_IGN 6
`define CTL_TGL 5
`define CTL_AUTO 4
`define CTL_TIMING 3
`define EV_NEXT_TGL 5
`define EV_HALT 0
`define EV_ERR 1
`define EV_CNT 2
`define EV_SHORT 3
`define RETRY_AUTO_ERR 7
`define RST_BYTE 8'h00
`endif

// ---- rtl/dma_pkg.sv ----
// Types of the auto DMA control block
package dma_pkg;
  typedef enum logic [2:0] {
    ST_IDLE, ST_RECV, ST_DRAIN, ST_FILL, ST_XMIT
  } auto_state_t;
endpackage : dma_pkg

// ---- rtl/usb_endpoint_auto_dma_control.sv ----
// DMA request and automatic DMA sequencing for USB bulk/iso endpoints
//
// Function
// - Timing clear: request on transfer completion
// - Timing set: request on FIFO warning
// - Transmit request hold and release conditions
// - Receive request hold and release conditions
// - Auto mode enables selected endpoint
// - Auto starts with events clear, stops on event
// - Receive then drain; fill then transmit
// - Auto mode ignores request timing select
// - Entering auto mode flushes endpoint FIFO
// - Auto cleared: finish operation, then halt flag
// - Enable cleared: stop at once, halt flag
// - Firmware FIFO access during DMA halts
// - Endpoint register access in auto halts
// - Initial toggle write loads next toggle, wins
// - Toggle flips per packet, overrides transmit toggle in auto
// - Ignore receive toggle mismatch when set
// - Enable resets clear, ignored in serial mode
// - Error flag on bad packet or mismatch
// - Auto error handling delays error flag
// - Count done flag and short packet flag
// - Masked events drive alternate DMA flag
// - Status mirror read has no side effect
// - Endpoint select codes, 11x reserved
// - Packet count decrements, write wins
`timescale 1ns/100ps
`include "dma_params.svh"
module usb_endpoint_auto_dma_control
  import dma_pkg::*;
#(
  parameter int NUM_EP = 6
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  input wire logic interface_select_pin,
  input wire logic [NUM_EP-1:0] ep_complete,
  input wire logic [NUM_EP-1:0] fifo_warn,
  input wire logic [NUM_EP-1:0] fifo_empty,
  input wire logic [NUM_EP-1:0] status_read,
  input wire logic [NUM_EP-1:0] tx_last_set,
  input wire logic [NUM_EP-1:0] ep_reg_access,
  input wire logic [NUM_EP-1:0] fifo_fw_access,
  input wire logic [8*NUM_EP-1:0] ep_status,
  input wire logic pkt_done,
  input wire logic pkt_ack,
  input wire logic pkt_rx_err,
  input wire logic pkt_toggle,
  input wire logic pkt_short,
  input wire logic dma_ack,
  output logic dma_req,
  output logic auto_rx_enable,
  output logic auto_tx_enable,
  output logic fifo_flush,
  output logic tx_toggle_override,
  output logic tx_toggle_value,
  output logic alt_event_dma
);

  function automatic logic pick(input logic [NUM_EP-1:0] v,
                                input logic [2:0] s);
    logic [7:0] w;
    w = 8'h00;
    w[NUM_EP-1:0] = v;
    return w[s];
  endfunction : pick

  logic [7:0] ctrl;
  logic [3:0] events;
  logic tgl_state;
  logic [3:0] mask;
  logic [7:0] count;
  logic auto_err;
  logic [6:0] preset;
  logic [6:0] retry;
  logic req_flag;
  logic cmp_q;
  logic warn_q;
  auto_state_t state;
  auto_state_t next_state;

  //////////////////////////////////////////////////////////////////////
  // Decode
  wire wr_ctrl = reg_write && reg_addr == `OFF_CONTROL;
  wire wr_event = reg_write && reg_addr == `OFF_EVENT;
  wire wr_mask = reg_write && reg_addr == `OFF_MASK;
  wire wr_count = reg_write && reg_addr == `OFF_COUNT;
  wire wr_retry = reg_write && reg_addr == `OFF_RETRY;
  wire [2:0] sel = ctrl[2:0];
  wire sel_ok = !(sel[2] && sel[1]);
  wire is_tx = !sel[0];
  wire en = ctrl[`CTL_EN];
  wire auto_bit = ctrl[`CTL_AUTO];
  wire auto_on = state != ST_IDLE;
  wire cmp = pick(ep_complete, sel);
  wire warn = pick(fifo_warn, sel);
  wire empty = pick(fifo_empty, sel);
  wire [7:0] mirror = sel_ok ? ep_status[8*sel +: 8] : 8'h00;

  //////////////////////////////////////////////////////////////////////
  // Packet outcome
  wire err_bad = is_tx ? !pkt_ack : pkt_rx_err;
  wire mism = pkt_toggle != tgl_state && (is_tx || !ctrl[`CTL_IGN]);
  wire pkt_fail = pkt_done && (err_bad || mism);
  wire pkt_good = pkt_done && !(err_bad || mism);
  // Retries swallow the error while the counter has room
  wire retry_ok = auto_err && auto_on && retry != 7'h00;
  wire set_err = pkt_fail && !retry_ok;
  wire op_done = (state == ST_DRAIN && dma_ack) ||
                 (state == ST_XMIT && pkt_good);
  wire ev_short = state == ST_RECV && pkt_good && pkt_short;
  wire ev_count = op_done && count == 8'h00;

  //////////////////////////////////////////////////////////////////////
  // Halt causes
  wire dma_active = auto_on || req_flag;
  wire hard_halt = (wr_ctrl && en && !reg_wdata[`CTL_EN]) ||
    (dma_active && pick(fifo_fw_access, sel)) ||
    (en && auto_bit && pick(ep_reg_access, sel));
  wire start = state == ST_IDLE && en && auto_bit && sel_ok &&
               events == 4'h0;
  logic soft_halt;

  always_comb begin
    next_state = state;
    soft_halt = 1'b0;
    case (state)
      ST_IDLE: begin
        if (start) begin
          next_state = is_tx ? ST_FILL : ST_RECV;
        end
      end
      ST_RECV: begin
        if (!auto_bit) begin
          next_state = ST_IDLE;
          soft_halt = 1'b1;
        end else if (pkt_good) begin
          next_state = ST_DRAIN;
        end
      end
      ST_DRAIN: begin
        if (dma_ack) begin
          next_state = auto_bit ? ST_RECV : ST_IDLE;
          soft_halt = !auto_bit;
        end
      end
      ST_FILL: begin
        if (dma_ack) begin
          next_state = ST_XMIT;
        end
      end
      ST_XMIT: begin
        if (pkt_good) begin
          next_state = auto_bit ? ST_FILL : ST_IDLE;
          soft_halt = !auto_bit;
        end
      end
      default: next_state = ST_IDLE;
    endcase
    // Leave at the edge that raises an event, so no extra request goes out
    if (hard_halt || events != 4'h0 || set_err || ev_short || ev_count ||
        !en) begin
      next_state = ST_IDLE;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Event flags: hardware set wins over a write-one clear
  wire [3:0] ev_set = {
    ev_short,
    ev_count,
    set_err,
    hard_halt || (soft_halt && !hard_halt && en)
  };
  wire [3:0] ev_clr = wr_event ? reg_wdata[3:0] : 4'h0;
  wire [3:0] next_events = (events & ~ev_clr) | ev_set;

  // Non-auto request: set wins over release
  wire req_set = ctrl[`CTL_TIMING] ? (warn && !warn_q)
                                 : (cmp && !cmp_q);
  wire req_clr = ctrl[`CTL_TIMING]
    ? (!warn || (is_tx ? cmp : empty))
    : (pick(status_read, sel) ||
       (is_tx ? pick(tx_last_set, sel) : empty));
  wire next_req = !auto_on && en && !hard_halt &&
                  (req_set || (req_flag && !req_clr));

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state <= ST_IDLE;
      events <= 4'h0;
      req_flag <= 1'b0;
      cmp_q <= 1'b0;
      warn_q <= 1'b0;
      fifo_flush <= 1'b0;
      alt_event_dma <= 1'b0;
    end else begin
      state <= next_state;
      events <= next_events;
      req_flag <= next_req;
      cmp_q <= cmp;
      warn_q <= warn;
      fifo_flush <= start;
      alt_event_dma <= |(next_events & (wr_mask ? reg_wdata[3:0]
                                                : mask));
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ctrl <= `RST_BYTE;
      mask <= 4'h0;
      tgl_state <= 1'b0;
      count <= `RST_BYTE;
      auto_err <= 1'b0;
      preset <= 7'h00;
      retry <= 7'h00;
    end else begin
      if (wr_ctrl) begin
        // Serial interface mode cannot enable DMA
        ctrl <= {reg_wdata[7] && !interface_select_pin,
                 reg_wdata[6:0]};
      end
      if (wr_mask) begin
        mask <= reg_wdata[3:0];
      end
      if (wr_ctrl) begin
        tgl_state <= reg_wdata[`CTL_TGL];
      end else if (pkt_done && !err_bad) begin
        tgl_state <= !tgl_state;
      end
      if (wr_count) begin
        count <= reg_wdata;
      end else if (op_done && count != 8'h00) begin
        count <= count - 8'h01;
      end
      if (wr_retry && !auto_on) begin
        auto_err <= reg_wdata[`RETRY_AUTO_ERR];
        preset <= reg_wdata[6:0];
        retry <= reg_wdata[6:0];
      end else if (!auto_on || pkt_good) begin
        retry <= preset;
      end else if (pkt_fail && retry_ok) begin
        retry <= retry - 7'h01;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Read port: data only in the cycle after the strobe
  logic [7:0] rd_mux;
  always_comb begin
    case (reg_addr)
      `OFF_CONTROL: rd_mux = ctrl;
      `OFF_EVENT: rd_mux = {2'b00, tgl_state, 1'b0, events};
      `OFF_MASK: rd_mux = {4'h0, mask};
      `OFF_MIRROR: rd_mux = mirror;
      `OFF_COUNT: rd_mux = count;
      `OFF_RETRY: rd_mux = {auto_err, auto_on ? retry : preset};
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= reg_read ? rd_mux : 8'h00;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Outputs
  // Auto mode requests in ST_DRAIN and ST_FILL, using neither completion nor warning timing
  assign dma_req = en && sel_ok && (auto_on
    ? (state == ST_DRAIN || state == ST_FILL)
    : req_flag);
  assign auto_rx_enable = state == ST_RECV;
  assign auto_tx_enable = state == ST_XMIT;
  assign tx_toggle_override = auto_on && is_tx;
  assign tx_toggle_value = tgl_state;

  //////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  property p_no_en_no_req;
    !en || !sel_ok |-> !dma_req;
  endproperty
  a_no_en_no_req: assert property (p_no_en_no_req)
    else $error("request while disabled");

  property p_en_clear_halts;
    wr_ctrl && en && !reg_wdata[`CTL_EN] |=> events[`EV_HALT] && !auto_on;
  endproperty
  a_en_clear_halts: assert property (p_en_clear_halts)
    else $error("enable clear did not halt");

  property p_tgl_write;
    wr_ctrl |=> tgl_state == $past(reg_wdata[`CTL_TGL]);
  endproperty
  a_tgl_write: assert property (p_tgl_write)
    else $error("toggle write lost");

  property p_event_stops;
    events != 4'h0 |=> !auto_on;
  endproperty
  a_event_stops: assert property (p_event_stops)
    else $error("auto mode ran with event set");

  property p_mirror;
    reg_read && reg_addr == `OFF_MIRROR |=> reg_rdata == $past(mirror);
  endproperty
  a_mirror: assert property (p_mirror)
    else $error("mirror read wrong");

  property p_count_write;
    wr_count |=> count == $past(reg_wdata);
  endproperty
  a_count_write: assert property (p_count_write)
    else $error("count write lost");

  property p_serial_mode;
    wr_ctrl && interface_select_pin |=> !en;
  endproperty
  a_serial_mode: assert property (p_serial_mode)
    else $error("enable set in serial mode");

  property p_recv_no_req;
    state == ST_RECV |-> !dma_req && auto_rx_enable;
  endproperty
  a_recv_no_req: assert property (p_recv_no_req)
    else $error("request while receiving");

  property p_reg_access_halt;
    en && auto_bit && pick(ep_reg_access, sel)
      |=> events[`EV_HALT] && !auto_on;
  endproperty
  a_reg_access_halt: assert property (p_reg_access_halt)
    else $error("register access did not halt");

  property p_flush;
    start |=> fifo_flush ##1 !fifo_flush;
  endproperty
  a_flush: assert property (p_flush)
    else $error("no flush on entry");

endmodule : usb_endpoint_auto_dma_control
